// ==== verilog/xfer_engine_map.svh ====
// Constants for the divided buffer transfer engine.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef XFER_ENGINE_MAP_SVH
`define XFER_ENGINE_MAP_SVH
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define WDT_DEFAULT_MS 16'h00c8
`define ERR_UNIT_ABSENT 16'h1a34
`define ERR_NONE 16'h0000
`define UNIT_SEL_MAX 3'h7
`define BUF_INDEX_MAX 15'h7ffe
`define BUF_DEPTH 2
`endif

// ==== verilog/xfer_engine_pkg.sv ====
// Types for the divided buffer transfer engine.
// Assumes nothing beyond a SystemVerilog compiler.
package xfer_engine_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_STOP = 2'b11
	} state_type;
	typedef enum logic {
		DIR_WRITE = 1'b0,
		DIR_READ = 1'b1
	} dir_type;
endpackage

// ==== verilog/divided_buffer_transfer_engine.sv ====
// Divided block transfer between controller data memory and unit buffer memory.
// Assumes a scan-end pulse on the core clock and memories answering via handshake.
`timescale 1ns/1ps
`include "xfer_engine_map.svh"

// Functional notes
// - Normal end of a transfer sets the instruction done flag.
// - Faulted end sets the abort flag instead of done.
// - Second start for a busy unit sets blocked flag and is held.
// - Held transfer resumes once the busy unit's transfer ends.
// - Absent unit raises operation error flag with code 6708.
// - Units are numbered upward from zero, nearest first.
// - With a built-in network master, external units start at one.
// - Unit buffer holds up to 32767 words; head index zero to 32766.
// - Write copies consecutive controller words into consecutive buffer words.
// - Watchdog time word resets to 200 ms and is writable.
// - Without refresh, a new watchdog time applies at scan end.
// - Drive removal suspends; words already moved stay in place.
// - Index value is captured at start; later changes are ignored.
// - Read copies consecutive buffer words into consecutive controller words.
// - At most the per-scan count moves each scan; ceiling scans total.
module divided_buffer_transfer_engine
	import xfer_engine_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Request
	input wire logic i_start,
	input wire logic i_dir_read,
	input wire logic i_drive,
	input wire logic [2:0] i_unit_select,
	input wire logic [14:0] i_head_buffer_index,
	input wire logic [15:0] i_ctrl_base,
	input wire logic [15:0] i_index_value,
	input wire logic [14:0] i_total_word_count,
	input wire logic [14:0] i_words_per_cycle,
	// Scan and watchdog
	input wire logic i_scan_end,
	input wire logic i_watchdog_refresh_instr,
	input wire logic i_wdt_write,
	input wire logic [15:0] i_wdt_data,
	input wire logic i_err_clear,
	// Unit presence pins
	input wire logic [7:0] i_unit_present,
	input wire logic i_builtin_master,
	// Fetch side
	output logic o_fetch_valid,
	input wire logic i_fetch_ready,
	output logic [15:0] o_fetch_addr,
	output logic o_from_unit,
	input wire logic i_fetch_rvalid,
	input wire logic [15:0] i_fetch_data,
	// Store side
	output logic o_store_valid,
	input wire logic i_store_ready,
	output logic [15:0] o_store_addr,
	output logic [15:0] o_store_data,
	input wire logic i_xfer_fault,
	// Unit addressing
	output logic [2:0] o_unit_slot,
	output logic o_unit_is_master,
	// Status
	output logic o_busy,
	output logic o_instr_done_flag,
	output logic o_instr_abort_flag,
	output logic o_instr_blocked_flag,
	output logic o_operation_error_flag,
	output logic [15:0] o_operation_error_code,
	output logic [15:0] o_watchdog_time_word,
	output logic o_watchdog_error,
	output logic [14:0] o_word_offset
);
	state_type state_ff;
	logic [1:0] pres_meta_ff, pres_sync_ff;
	logic [7:0] unit_meta_ff, unit_sync_ff;
	logic dir_ff;
	logic [2:0] unit_ff;
	logic [14:0] total_ff, per_ff, quota_ff, fetch_cnt_ff;
	logic outstanding_ff;
	logic pend_ff, pend_dir_ff;
	logic [2:0] pend_unit_ff;
	logic [15:0] pend_unit_addr_ff, pend_ctrl_addr_ff;
	logic [14:0] pend_total_ff, pend_per_ff;
	logic [15:0] fifo_mem [`BUF_DEPTH];
	logic fifo_wp_ff, fifo_rp_ff;
	logic [1:0] fifo_cnt_ff;
	logic [15:0] wdt_limit_ff, wdt_ms_ff;
	logic [$clog2(MS_CYCLES)-1:0] ms_div_ff;
	logic ms_tick;
	logic launch, launch_new, launch_pend, present, hold_new;
	logic [2:0] l_unit;
	logic l_dir;
	logic [15:0] l_unit_addr, l_ctrl_addr;
	logic [14:0] l_total, l_per;
	logic fetch_acc, store_acc, push, finish, abort_run, wdt_trip;

	// Pins from outside the clock domain
	always_ff @(posedge i_clk) begin
		unit_meta_ff <= i_unit_present;
		unit_sync_ff <= unit_meta_ff;
		pres_meta_ff <= {pres_meta_ff[0], i_builtin_master};
		pres_sync_ff <= {pres_sync_ff[0], pres_meta_ff[1]};
	end

	// index captured at start, also for a held start; 15-bit head index widened to 16
	always_comb begin
		launch_new = i_start && state_ff == ST_IDLE && !pend_ff;
		launch_pend = pend_ff && state_ff == ST_IDLE && !i_start;
		launch = launch_new || launch_pend;
		hold_new = i_start && !launch_new && !pend_ff;
		l_unit = launch_pend ? pend_unit_ff : i_unit_select;
		l_dir = launch_pend ? pend_dir_ff : i_dir_read;
		l_total = launch_pend ? pend_total_ff : i_total_word_count;
		l_per = launch_pend ? pend_per_ff : i_words_per_cycle;
		l_unit_addr = launch_pend ? pend_unit_addr_ff
			: {1'b0, i_head_buffer_index} + i_index_value;
		l_ctrl_addr = launch_pend ? pend_ctrl_addr_ff : i_ctrl_base + i_index_value;
	end

	// upward numbering; built-in master takes number zero
	always_comb begin
		o_unit_is_master = pres_sync_ff[1] && unit_ff == 3'h0;
		o_unit_slot = pres_sync_ff[1] ? unit_ff - 3'h1 : unit_ff;
		if (pres_sync_ff[1] && l_unit == 3'h0) begin
			present = 1'b1;
		end else begin
			present = unit_sync_ff[pres_sync_ff[1] ? l_unit - 3'h1 : l_unit];
		end
	end

	assign fetch_acc = o_fetch_valid && i_fetch_ready;
	assign store_acc = o_store_valid && i_store_ready;
	assign push = i_fetch_rvalid && outstanding_ff;
	assign finish = state_ff == ST_RUN && store_acc && o_word_offset + 15'h1 == total_ff;
	assign abort_run = state_ff == ST_RUN && (i_xfer_fault || wdt_trip);

	// fetch only while scan quota and buffer room remain
	assign o_fetch_valid = state_ff == ST_RUN && i_drive && quota_ff != 15'h0
		&& fetch_cnt_ff != total_ff && !outstanding_ff
		&& fifo_cnt_ff != 2'(`BUF_DEPTH);
	assign o_store_valid = state_ff == ST_RUN && fifo_cnt_ff != 2'h0;
	assign o_store_data = fifo_mem[fifo_rp_ff];
	assign o_busy = state_ff != ST_IDLE;
	assign o_from_unit = dir_ff;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (launch && present) begin
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (finish) begin
						state_ff <= ST_IDLE;
					end else if (abort_run || !i_drive) begin
						state_ff <= ST_STOP;
					end
				end
				ST_STOP: begin
					// Wait out an in-flight fetch so its answer is not mistaken later
					if (!outstanding_ff || i_fetch_rvalid) begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Captured operands
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			dir_ff <= 1'b0;
			unit_ff <= 3'h0;
			total_ff <= 15'h0;
			per_ff <= 15'h0;
		end else if (launch && present) begin
			dir_ff <= l_dir;
			unit_ff <= l_unit;
			total_ff <= l_total;
			per_ff <= l_per;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_fetch_addr <= 16'h0;
			o_store_addr <= 16'h0;
		end else if (launch && present) begin
			o_fetch_addr <= l_dir ? l_unit_addr : l_ctrl_addr;
			o_store_addr <= l_dir ? l_ctrl_addr : l_unit_addr;
		end else begin
			if (fetch_acc) begin
				o_fetch_addr <= o_fetch_addr + 16'h1;
			end
			if (store_acc) begin
				o_store_addr <= o_store_addr + 16'h1;
			end
		end
	end

	// per-scan quota reloaded at every scan end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			quota_ff <= 15'h0;
			fetch_cnt_ff <= 15'h0;
			outstanding_ff <= 1'b0;
		end else begin
			if (launch && present) begin
				quota_ff <= l_per;
			end else if (i_scan_end) begin
				quota_ff <= per_ff;
			end else if (fetch_acc) begin
				quota_ff <= quota_ff - 15'h1;
			end
			if (launch && present) begin
				fetch_cnt_ff <= 15'h0;
			end else if (fetch_acc) begin
				fetch_cnt_ff <= fetch_cnt_ff + 15'h1;
			end
			if (fetch_acc) begin
				outstanding_ff <= 1'b1;
			end else if (i_fetch_rvalid) begin
				outstanding_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_word_offset <= 15'h0;
		end else if (launch && present) begin
			o_word_offset <= 15'h0;
		end else if (store_acc) begin
			o_word_offset <= o_word_offset + 15'h1;
		end
	end

	// Two-entry buffer; a stalled store holds fetches off
	always_ff @(posedge i_clk) begin
		if (!i_nrst || state_ff == ST_IDLE) begin
			fifo_wp_ff <= 1'b0;
			fifo_rp_ff <= 1'b0;
			fifo_cnt_ff <= 2'h0;
		end else begin
			if (push && state_ff == ST_RUN) begin
				fifo_mem[fifo_wp_ff] <= i_fetch_data;
				fifo_wp_ff <= ~fifo_wp_ff;
			end
			if (store_acc) begin
				fifo_rp_ff <= ~fifo_rp_ff;
			end
			fifo_cnt_ff <= fifo_cnt_ff + 2'(push && state_ff == ST_RUN) - 2'(store_acc);
		end
	end

	// hold a start that arrives while the engine is busy and none is held yet, whatever its unit
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pend_ff <= 1'b0;
			pend_dir_ff <= 1'b0;
			pend_unit_ff <= 3'h0;
			pend_unit_addr_ff <= 16'h0;
			pend_ctrl_addr_ff <= 16'h0;
			pend_total_ff <= 15'h0;
			pend_per_ff <= 15'h0;
		end else if (hold_new) begin
			pend_ff <= 1'b1;
			pend_dir_ff <= i_dir_read;
			pend_unit_ff <= i_unit_select;
			pend_unit_addr_ff <= {1'b0, i_head_buffer_index} + i_index_value;
			pend_ctrl_addr_ff <= i_ctrl_base + i_index_value;
			pend_total_ff <= i_total_word_count;
			pend_per_ff <= i_words_per_cycle;
		end else if (launch_pend) begin
			// resume once the unit is free
			pend_ff <= 1'b0;
		end
	end

	// completion and blocked flags; a set beats a clear
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_instr_done_flag <= 1'b0;
			o_instr_abort_flag <= 1'b0;
			o_instr_blocked_flag <= 1'b0;
		end else begin
			if (finish) begin
				o_instr_done_flag <= 1'b1;
			end else if (launch) begin
				o_instr_done_flag <= 1'b0;
			end
			if (abort_run || (launch && !present)) begin
				o_instr_abort_flag <= 1'b1;
			end else if (launch) begin
				o_instr_abort_flag <= 1'b0;
			end
			if (hold_new && o_busy && i_unit_select == unit_ff) begin
				o_instr_blocked_flag <= 1'b1;
			end else if (launch_pend) begin
				o_instr_blocked_flag <= 1'b0;
			end
		end
	end

	// absent unit reports the operation error
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_operation_error_flag <= 1'b0;
			o_operation_error_code <= `ERR_NONE;
		end else if (launch && !present) begin
			o_operation_error_flag <= 1'b1;
			o_operation_error_code <= `ERR_UNIT_ABSENT;
		end else if (i_err_clear) begin
			o_operation_error_flag <= 1'b0;
		end
	end

	// watchdog time word; takes effect at refresh or scan end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_watchdog_time_word <= `WDT_DEFAULT_MS;
			wdt_limit_ff <= `WDT_DEFAULT_MS;
		end else begin
			if (i_wdt_write) begin
				o_watchdog_time_word <= i_wdt_data;
			end
			if (i_watchdog_refresh_instr || i_scan_end) begin
				wdt_limit_ff <= o_watchdog_time_word;
			end
		end
	end

	assign ms_tick = ms_div_ff == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
	assign wdt_trip = wdt_ms_ff >= wdt_limit_ff;

	// Millisecond watchdog; a long scan aborts the running transfer
	always_ff @(posedge i_clk) begin
		if (!i_nrst || i_watchdog_refresh_instr || i_scan_end) begin
			ms_div_ff <= '0;
			wdt_ms_ff <= 16'h0;
		end else begin
			ms_div_ff <= ms_tick ? '0 : ms_div_ff + 1'b1;
			if (ms_tick && !wdt_trip) begin
				wdt_ms_ff <= wdt_ms_ff + 16'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_watchdog_error <= 1'b0;
		end else if (wdt_trip) begin
			o_watchdog_error <= 1'b1;
		end else if (i_err_clear) begin
			o_watchdog_error <= 1'b0;
		end
	end

	// Assertions
	a_done_on_last: assert property (@(posedge i_clk) disable iff (!i_nrst)
		finish |=> o_instr_done_flag && state_ff == ST_IDLE)
		else $error("done flag missing after last word");
	a_abort_no_done: assert property (@(posedge i_clk) disable iff (!i_nrst)
		abort_run && !finish |=> o_instr_abort_flag && !o_instr_done_flag)
		else $error("abort did not set abort flag");
	a_blocked_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(hold_new && o_busy && i_unit_select == unit_ff) |=> o_instr_blocked_flag && pend_ff)
		else $error("same-unit start not held");
	a_resume_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(pend_ff && state_ff == ST_IDLE && !i_start) |-> ##1 !pend_ff)
		else $error("held transfer did not resume");
	a_error_code: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(launch && !present) |=> o_operation_error_flag
			&& o_operation_error_code == 16'h1a34 && state_ff == ST_IDLE)
		else $error("absent unit not reported");
	a_scan_quota: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state_ff == ST_RUN && !i_scan_end && !launch |-> quota_ff <= per_ff)
		else $error("quota above per-scan count");
	a_offset_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
		store_acc && state_ff == ST_RUN |=> o_word_offset == $past(o_word_offset) + 15'h1)
		else $error("offset did not advance by one");
	a_suspend_stop: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state_ff == ST_RUN && !i_drive && !finish |=> state_ff == ST_STOP ##[1:300] state_ff == ST_IDLE)
		else $error("drive removal did not suspend");
	a_wdt_reset: assert property (@(posedge i_clk)
		!i_nrst |=> o_watchdog_time_word == 16'h00c8)
		else $error("watchdog word reset value wrong");
	a_wdt_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_scan_end && !i_watchdog_refresh_instr |=> wdt_limit_ff == $past(o_watchdog_time_word))
		else $error("watchdog time not applied at scan end");
	a_master_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
		pres_sync_ff[1] && unit_ff == 3'h2 |-> o_unit_slot == 3'h1)
		else $error("external numbering not shifted");
	c_normal_end: cover property (@(posedge i_clk) disable iff (!i_nrst) finish);
	c_blocked: cover property (@(posedge i_clk) disable iff (!i_nrst)
		o_instr_blocked_flag ##[1:1000] launch_pend);
	c_stall_full: cover property (@(posedge i_clk) disable iff (!i_nrst)
		fifo_cnt_ff == 2'h2 && !i_store_ready);
	c_absent: cover property (@(posedge i_clk) disable iff (!i_nrst) launch && !present);
endmodule // divided_buffer_transfer_engine

// ==== dv/xfer_mem_model.sv ====
// Memory model for both far sides of the transfer engine.
// Assumes handshakes sampled at posedge; drives its outputs at negedge.
`timescale 1ns/1ps
module xfer_mem_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_slow,
	// Fetch side
	input wire logic i_fetch_valid,
	input wire logic [15:0] i_fetch_addr,
	input wire logic i_from_unit,
	output logic o_fetch_ready = 1'b0,
	output logic o_fetch_rvalid = 1'b0,
	output logic [15:0] o_fetch_data = 16'h0000,
	// Store side
	output logic o_store_ready = 1'b0
);
	logic took = 1'b0;
	logic u = 1'b0;
	logic pend = 1'b0;
	logic [15:0] a = 16'h0000;
	logic [31:0] r;
	int seed = 32'h32485244;
	int cnt = 0;
	always @(posedge i_clk) begin
		took <= i_fetch_valid & o_fetch_ready;
		if (i_fetch_valid & o_fetch_ready) begin
			a <= i_fetch_addr;
			u <= i_from_unit;
		end
	end
	always @(negedge i_clk) begin
		r = $random(seed);
		o_fetch_rvalid = 1'b0;
		// Idle data line toggles so a stale word never looks valid
		o_fetch_data = ~o_fetch_data;
		o_fetch_ready = !i_slow | r[0];
		o_store_ready = !i_slow | r[1];
		if (took) begin
			pend = 1'b1;
			cnt = i_slow ? r[3:2] : 0;
		end
		// source words fixed per address for the whole run
		if (pend && cnt == 0) begin
			pend = 1'b0;
			o_fetch_rvalid = 1'b1;
			o_fetch_data = a ^ (u ? 16'h5a3c : 16'hc3a5);
		end else if (pend) begin
			cnt = cnt - 1;
		end
		if (!i_nrst) begin
			pend = 1'b0;
			o_fetch_rvalid = 1'b0;
		end
	end
endmodule // xfer_mem_model

// ==== dv/divided_buffer_transfer_engine_test.sv ====
// Self-checking bench for the divided buffer transfer engine.
// Assumes the memory model answers both sides; inputs move at negedge.
`timescale 1ns/1ps
`include "xfer_engine_map.svh"
module divided_buffer_transfer_engine_test;
	typedef struct {logic [15:0] f, s; logic [14:0] t, w; logic d;} desc_type;
	logic clk = 0, nrst = 0, start = 0, rd = 0, drive = 1, scan = 0, wdr = 0, wdw = 0;
	logic clr = 0, master = 0, fault = 0, slow = 0;
	logic [2:0] unit = 0;
	logic [14:0] head = 0, tot = 1, wpc = 1;
	logic [15:0] base = 0, idx = 0, wdd = 0;
	logic [7:0] pres = 8'hff;
	logic [31:0] r;
	wire logic fv, fr, frv, fu, sv, sr, busy, done, abrt, blk, oerr, ism, wde;
	wire logic [15:0] fa, fd, sa, sd, ecode, wdt;
	wire logic [14:0] off;
	wire logic [2:0] slot;
	int errors = 0, n_checks = 0, seed = 32'h32485244, cyc = 0, k = 0, nf = 0;
	desc_type q[$];
	divided_buffer_transfer_engine #(.MS_CYCLES(10)) u_dut (.i_clk(clk), .i_nrst(nrst),
		.i_start(start), .i_dir_read(rd), .i_drive(drive), .i_unit_select(unit),
		.i_head_buffer_index(head), .i_ctrl_base(base), .i_index_value(idx),
		.i_total_word_count(tot), .i_words_per_cycle(wpc), .i_scan_end(scan),
		.i_watchdog_refresh_instr(wdr), .i_wdt_write(wdw), .i_wdt_data(wdd),
		.i_err_clear(clr), .i_unit_present(pres), .i_builtin_master(master),
		.o_fetch_valid(fv), .i_fetch_ready(fr), .o_fetch_addr(fa), .o_from_unit(fu),
		.i_fetch_rvalid(frv), .i_fetch_data(fd), .o_store_valid(sv), .i_store_ready(sr),
		.o_store_addr(sa), .o_store_data(sd), .i_xfer_fault(fault), .o_unit_slot(slot),
		.o_unit_is_master(ism), .o_busy(busy), .o_instr_done_flag(done),
		.o_instr_abort_flag(abrt), .o_instr_blocked_flag(blk),
		.o_operation_error_flag(oerr), .o_operation_error_code(ecode),
		.o_watchdog_time_word(wdt), .o_watchdog_error(wde), .o_word_offset(off));
	xfer_mem_model u_mem (.i_clk(clk), .i_nrst(nrst), .i_slow(slow), .i_fetch_valid(fv),
		.i_fetch_addr(fa), .i_from_unit(fu), .o_fetch_ready(fr), .o_fetch_rvalid(frv),
		.o_fetch_data(fd), .o_store_ready(sr));
	always #10 clk = ~clk;
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chkf(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask
	task automatic chkw(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	function automatic int scans(input int t, input int w);
		return (t + w - 1) / w - 1;
	endfunction
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			close_out;
		end
	end
	// Scan end every 80 cycles, long enough for five slow words
	always @(negedge clk) scan = (cyc % 80 == 0);
	always @(posedge clk) begin
		if (fv && fr) begin
			nf++;
			chkf(nf <= q[0].w, 1'b1, "words per scan");
			chkf(fu, q[0].d, "direction");
		end
		if (scan)
			nf = 0;
		if (sv && sr) begin
			chkw(sa, q[0].s + 16'(k), "store addr");
			chkw(sd, (q[0].f + 16'(k)) ^ (q[0].d ? 16'h5a3c : 16'hc3a5), "data");
			k++;
			if (k == int'(q[0].t)) begin
				q.pop_front();
				k = 0;
				nf = 0;
			end
		end
	end
	task automatic go(input logic d, input logic [2:0] un, input logic [14:0] t, w,
		input logic al);
		desc_type e;
		if (al)
			@(posedge clk iff scan);
		@(negedge clk);
		r = $random(seed);
		rd = d;
		unit = un;
		tot = t;
		wpc = w;
		// head index kept within 0 to 32766
		head = r[14:0] % 15'h7fff;
		base = $random(seed);
		idx = r[31:16];
		e.d = d;
		e.t = t;
		e.w = w;
		e.f = d ? {1'b0, head} + idx : base + idx;
		e.s = d ? base + idx : {1'b0, head} + idx;
		q.push_back(e);
		start = 1;
		@(negedge clk);
		start = 0;
		// index moved after start has no effect on the run
		idx = ~idx;
		chkw({13'h0, slot}, {13'h0, un - {2'b0, master}}, "slot");
		chkf(ism, master && un == 0, "master");
	endtask
	task automatic fin(input int t, input int w);
		int s;
		s = 0;
		for (int i = 0; i < 4000 && busy === 1'b1; i++) begin
			@(posedge clk);
			s += scan;
			// Let the edge settle before busy is tested
			#1;
		end
		@(negedge clk);
		chkf(done, 1'b1, "done");
		chkf(abrt, 1'b0, "abort");
		chkw({1'b0, off}, {1'b0, tot}, "offset");
		chkw(16'(s), 16'(scans(t, w)), "scans");
	endtask
	initial begin
		repeat (20) @(negedge clk);
		nrst = 1;
		chkw(wdt, `WDT_DEFAULT_MS, "wdt reset");
		wdd = 16'h012c;
		wdw = 1;
		@(negedge clk);
		wdw = 0;
		wdr = 1;
		@(negedge clk);
		wdr = 0;
		chkw(wdt, 16'h012c, "wdt write");
		// corner counts, then random ones within range
		go(0, 7, 1, 1, 1); fin(1, 1);
		go(1, 5, 3, 15'h7fff, 1); fin(3, 32767);
		for (int i = 0; i < 14; i++) begin
			r = $random(seed);
			slow = r[0];
			go(r[1], r[4:2], 15'(r[8:5] % 12 + 1), 15'(r[11:9] % 5 + 1), 1);
			fin(tot, wpc);
		end
		master = 1;
		repeat (3) @(negedge clk);
		go(0, 2, 2, 1, 1); fin(2, 1);
		go(1, 0, 1, 1, 1); fin(1, 1);
		master = 0;
		go(0, 3, 8, 2, 1);
		go(1, 3, 3, 3, 0);
		@(negedge clk);
		chkf(blk, 1'b1, "blocked");
		for (int i = 0; i < 4000 && (q.size() > 0 || busy !== 1'b0); i++)
			@(negedge clk);
		chkf(blk, 1'b0, "resumed");
		chkf(done, 1'b1, "resumed done");
		for (int c = 0; c < 2; c++) begin
			go(c[0], 4, 30, 2, 1);
			for (int i = 0; i < 4000 && off < 3; i++)
				@(negedge clk);
			fault = c[0];
			drive = c[0];
			@(negedge clk);
			fault = 0;
			for (int i = 0; i < 200 && busy !== 1'b0; i++)
				@(negedge clk);
			chkf(done, 1'b0, "stopped done");
			chkf(abrt, c[0], "fault abort");
			drive = 1;
			q.pop_front();
			k = 0;
			nf = 0;
		end
		// short watchdog time trips during a run and aborts it
		chkf(wde, 1'b0, "watchdog quiet");
		wdd = 16'h0002;
		wdw = 1;
		@(negedge clk);
		wdw = 0;
		wdr = 1;
		@(negedge clk);
		wdr = 0;
		go(0, 4, 30, 2, 1);
		for (int i = 0; i < 200 && busy !== 1'b0; i++)
			@(negedge clk);
		chkf(abrt, 1'b1, "watchdog abort");
		chkf(wde, 1'b1, "watchdog error");
		q.pop_front();
		k = 0;
		nf = 0;
		wdd = 16'h012c;
		wdw = 1;
		@(negedge clk);
		wdw = 0;
		wdr = 1;
		@(negedge clk);
		wdr = 0;
		pres = 8'hfb;
		repeat (3) @(negedge clk);
		unit = 2;
		start = 1;
		@(negedge clk);
		start = 0;
		@(negedge clk);
		chkf(oerr, 1'b1, "error flag");
		chkw(ecode, `ERR_UNIT_ABSENT, "error code");
		chkf(busy, 1'b0, "absent idle");
		chkf(abrt, 1'b1, "absent abort");
		clr = 1;
		@(negedge clk);
		clr = 0;
		@(negedge clk);
		chkf(oerr, 1'b0, "error clear");
		chkf(wde, 1'b0, "watchdog clear");
		close_out;
	end
endmodule // divided_buffer_transfer_engine_test
